// ==== hw/omsp_div4.sv ====
`timescale 1ns/10ps
module omsp_div4
	import omsp_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic run,
	output logic      div_out
);

	logic [1:0] phase_reg;

	// Two-bit phase counter, stopped while the clock is not running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= 2'h0;
		end else if (ce && run) begin
			phase_reg <= phase_reg + 2'h1;
		end
	end

	// High for two of every four cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_out <= 1'b0;
		end else if (ce) begin
			div_out <= run & phase_reg[1];
		end
	end

endmodule

// ==== hw/omsp_top.sv ====
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
//Behaviour
// - Ten oscillator modes from four-bit field
// - Crystal PLL only for encoding 0110
// - Crystal PLL multiplies up to 10MHz by four
// - Multiplier enable ignored in crystal PLL mode
// - External clock: divided-by-four on output pin
// - External clock GPIO: output pin is bit six
// - External clock modes start without delay
// - RC mode: divided-by-four on output pin
// - RC GPIO mode: output pin is bit six
// - Internal clkout: div four out, input bit seven
// - Internal dual GPIO: both pins are GPIO
// - Crystal modes use both pins for resonator
// - Fast crystal also accepts external clock
// - Fast internal 8MHz, postscaler 31kHz to 4MHz
// - Fast oscillator on for 125kHz to 8MHz
// - Slow oscillator on when selected or needed
// - Frequency select field picks internal clock
// - Tuning settles: fast 1ms, slow 8 ticks
// - No completion flag for tuning settle
// - Source bit picks 31kHz oscillator
// - Software multiplier enable gives internal PLL
// - Internal PLL needs internal mode and 4/8MHz
// - Multiplier enable forced zero outside internal modes
module omsp_top
	import omsp_pkg::*;
#(
	parameter int FAST_SETTLE = FAST_SETTLE_CYC,
	parameter int SLOW_SETTLE = SLOW_SETTLE_CYC,
	parameter int START_DELAY = START_DELAY_CYC
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  oscillator_mode_field,
	input  wire logic        sleep_req,
	input  wire logic        pwrup_timer_en,
	input  wire logic        failsafe_mon_en,
	input  wire logic        watchdog_en,
	input  wire logic        two_speed_en,
	input  wire logic        oscillator_input_pin_in,
	output logic             oscillator_input_pin_out,
	output logic             oscillator_input_pin_oe,
	input  wire logic        oscillator_output_pin_in,
	output logic             oscillator_output_pin_out,
	output logic             oscillator_output_pin_oe,
	input  wire logic        port_a_bit_six_out,
	input  wire logic        port_a_bit_six_oe,
	output logic             port_a_bit_six_in,
	input  wire logic        port_a_bit_seven_out,
	input  wire logic        port_a_bit_seven_oe,
	output logic             port_a_bit_seven_in,
	output logic             resonator_en,
	output logic             ext_clock_accept,
	output logic             rc_osc_en,
	output logic             xtal_pll_en,
	output logic             int_pll_en,
	output logic             fast_osc_en,
	output logic             slow_osc_en,
	output logic             postscaler_en,
	output logic [2:0]       internal_frequency_select,
	output logic             slow_from_fast,
	output logic [4:0]       fast_trim,
	output logic             fast_trim_settling,
	output logic             slow_trim_settling,
	output logic             sys_clk_run
);

	localparam logic [31:0] FAST_LOAD = 32'(FAST_SETTLE - 1);
	localparam logic [31:0] SLOW_LOAD = 32'(SLOW_SETTLE - 1);
	localparam logic [31:0] START_LOAD = 32'(START_DELAY - 1);

	// Mode class decoders
	function automatic logic is_xtal(input logic [3:0] m);
		return (m == MODE_LP_XTAL) || (m == MODE_STD_XTAL) || (m == MODE_FAST_XTAL) || (m == MODE_XTAL_PLL);
	endfunction

	function automatic logic is_ext(input logic [3:0] m);
		return (m == MODE_EXT_DIV) || (m == MODE_EXT_GPIO);
	endfunction

	function automatic logic is_int(input logic [3:0] m);
		return (m == MODE_INT_DUAL) || (m == MODE_INT_CLKO);
	endfunction

	function automatic logic is_rc(input logic [3:0] m);
		return !is_xtal(m) && !is_ext(m) && !is_int(m);
	endfunction

	logic [3:0]  mode_reg;
	logic        loaded_reg;
	logic [2:0]  ifs_reg;
	logic        srcsel_reg;
	logic        mulen_reg;
	logic [4:0]  trim_reg;
	logic [31:0] fast_cnt_reg;
	logic [31:0] slow_cnt_reg;
	logic [31:0] start_cnt_reg;
	omsp_state_e state_reg;
	omsp_state_e state_next;
	logic        pin6_meta_reg;
	logic        pin6_sync_reg;
	logic        pin7_meta_reg;
	logic        pin7_sync_reg;
	logic        setup;
	logic        wr_en;
	logic        mapped;
	logic        pll_ok;
	logic        clkout_mode;
	logic        pin6_gpio;
	logic        pin7_gpio;
	logic        div4;
	logic        run;
	logic [31:0] rd_word;

	// Latch the mode field once, on the first edge after reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg   <= MODE_LP_XTAL;
			loaded_reg <= 1'b0;
		end else if (ce && !loaded_reg) begin
			mode_reg   <= oscillator_mode_field;
			loaded_reg <= 1'b1;
		end
	end

	// APB decode: one setup cycle, zero-wait access phase
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pwrite && ce;
	assign mapped  = (paddr == CTRL_OFS) || (paddr == TUNE_OFS) || (paddr == STATUS_OFS);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Control register: internal frequency select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ifs_reg <= IFS_RESET;
		end else if (wr_en && paddr == CTRL_OFS) begin
			ifs_reg <= pwdata[IFS_LSB +: 3];
		end
	end

	// Tuning register; multiplier enable held at zero outside internal modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srcsel_reg <= 1'b0;
			mulen_reg  <= 1'b0;
			trim_reg   <= TRIM_RESET;
		end else if (ce) begin
			if (wr_en && paddr == TUNE_OFS) begin
				srcsel_reg <= pwdata[SRCSEL_BIT];
				mulen_reg  <= pwdata[MULEN_BIT] && is_int(mode_reg);
				trim_reg   <= pwdata[4:0];
			end else if (!is_int(mode_reg)) begin
				mulen_reg <= 1'b0;
			end
		end
	end

	// Settle timers after a write that changes the trim; they are not visible to software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_cnt_reg <= 32'h0;
			slow_cnt_reg <= 32'h0;
		end else if (ce) begin
			if (wr_en && paddr == TUNE_OFS && pwdata[4:0] != trim_reg) begin
				fast_cnt_reg <= FAST_LOAD;
				slow_cnt_reg <= SLOW_LOAD;
			end else begin
				if (fast_cnt_reg != 32'h0) begin
					fast_cnt_reg <= fast_cnt_reg - 32'h1;
				end
				if (slow_cnt_reg != 32'h0) begin
					slow_cnt_reg <= slow_cnt_reg - 32'h1;
				end
			end
		end
	end

	assign fast_trim          = trim_reg;
	assign fast_trim_settling = (fast_cnt_reg != 32'h0);
	assign slow_trim_settling = (slow_cnt_reg != 32'h0);

	// Read data: captured in the setup cycle, presented in the access phase
	always_comb begin
		rd_word = 32'h0;
		unique case (paddr)
			CTRL_OFS: begin
				rd_word[IFS_LSB +: 3] = ifs_reg;
			end
			TUNE_OFS: begin
				rd_word[SRCSEL_BIT] = srcsel_reg;
				rd_word[MULEN_BIT]  = mulen_reg;
				rd_word[4:0]        = trim_reg;
			end
			STATUS_OFS: begin
				rd_word[ST_MODE_LSB +: 4] = mode_reg;
				rd_word[ST_XPLL_BIT]      = xtal_pll_en;
				rd_word[ST_IPLL_BIT]      = int_pll_en;
				rd_word[ST_FAST_BIT]      = fast_osc_en;
				rd_word[ST_SLOW_BIT]      = slow_osc_en;
				rd_word[ST_RUN_BIT]       = sys_clk_run;
			end
			default: begin
				rd_word = 32'h0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (ce && setup) begin
			prdata <= rd_word;
		end
	end

	// Multiplier paths
	assign pll_ok      = (ifs_reg == IFS_8MHZ) || (ifs_reg == IFS_4MHZ);
	assign xtal_pll_en = (mode_reg == MODE_XTAL_PLL);
	assign int_pll_en  = is_int(mode_reg) && pll_ok && mulen_reg;

	// Internal block enables
	assign internal_frequency_select = ifs_reg;
	assign slow_from_fast = (ifs_reg == IFS_31KHZ) && srcsel_reg;
	assign fast_osc_en    = is_int(mode_reg) && ((ifs_reg != IFS_31KHZ) || srcsel_reg);
	assign postscaler_en  = fast_osc_en && (ifs_reg != IFS_8MHZ);
	assign slow_osc_en    = (is_int(mode_reg) && ifs_reg == IFS_31KHZ && !srcsel_reg)
		|| pwrup_timer_en || failsafe_mon_en || watchdog_en || two_speed_en;

	// Oscillator front end
	assign resonator_en     = is_xtal(mode_reg);
	assign ext_clock_accept = is_ext(mode_reg) || (mode_reg == MODE_FAST_XTAL);
	assign rc_osc_en        = is_rc(mode_reg);

	// Start-up sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_LOAD: begin
				if (loaded_reg) begin
					state_next = is_ext(mode_reg) ? ST_RUN : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (sleep_req) begin
					state_next = ST_SLEEP;
				end else if (start_cnt_reg == 32'h0) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sleep_req) begin
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (!sleep_req) begin
					state_next = is_ext(mode_reg) ? ST_RUN : ST_WAIT;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_LOAD;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// Start-up delay counter, reloaded whenever waiting begins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_cnt_reg <= 32'h0;
		end else if (ce) begin
			if (state_next == ST_WAIT && state_reg != ST_WAIT) begin
				start_cnt_reg <= START_LOAD;
			end else if (start_cnt_reg != 32'h0) begin
				start_cnt_reg <= start_cnt_reg - 32'h1;
			end
		end
	end

	assign run         = (state_reg == ST_RUN);
	assign sys_clk_run = run;

	// Divided clock for the output pin
	omsp_div4 u_div4 (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.run     (run),
		.div_out (div4)
	);

	// Pin function selection
	assign clkout_mode = (mode_reg == MODE_EXT_DIV) || is_rc(mode_reg) && (mode_reg != MODE_RC_GPIO)
		|| (mode_reg == MODE_INT_CLKO);
	assign pin6_gpio   = (mode_reg == MODE_EXT_GPIO) || (mode_reg == MODE_RC_GPIO)
		|| (mode_reg == MODE_INT_DUAL);
	assign pin7_gpio   = is_int(mode_reg);

	// Output pin: divided clock, bit six, or resonator
	always_comb begin
		if (clkout_mode) begin
			oscillator_output_pin_out = div4;
			oscillator_output_pin_oe  = 1'b1;
		end else if (pin6_gpio) begin
			oscillator_output_pin_out = port_a_bit_six_out;
			oscillator_output_pin_oe  = port_a_bit_six_oe;
		end else begin
			oscillator_output_pin_out = 1'b0;
			oscillator_output_pin_oe  = 1'b0;
		end
	end

	// Input pin: bit seven in internal modes, clock input otherwise
	assign oscillator_input_pin_out = pin7_gpio ? port_a_bit_seven_out : 1'b0;
	assign oscillator_input_pin_oe  = pin7_gpio ? port_a_bit_seven_oe : 1'b0;

	// Pin read-back synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin6_meta_reg <= 1'b0;
			pin6_sync_reg <= 1'b0;
			pin7_meta_reg <= 1'b0;
			pin7_sync_reg <= 1'b0;
		end else if (ce) begin
			pin6_meta_reg <= oscillator_output_pin_in;
			pin6_sync_reg <= pin6_meta_reg;
			pin7_meta_reg <= oscillator_input_pin_in;
			pin7_sync_reg <= pin7_meta_reg;
		end
	end

	assign port_a_bit_six_in   = pin6_gpio & pin6_sync_reg;
	assign port_a_bit_seven_in = pin7_gpio & pin7_sync_reg;

endmodule

// ==== shared/omsp_pkg.sv ====
package omsp_pkg;

	// Clock rate and derived timing
	localparam int CLK_HZ            = 40_000_000;
	localparam int CLK_PERIOD_NS     = 25;
	localparam int FAST_SETTLE_US    = 1000;
	localparam int SLOW_SETTLE_TICKS = 8;
	localparam int SLOW_TICK_NS      = 32000;
	localparam int FAST_SETTLE_CYC   = FAST_SETTLE_US * (CLK_HZ / 1_000_000);
	localparam int SLOW_SETTLE_CYC   = SLOW_SETTLE_TICKS * SLOW_TICK_NS / CLK_PERIOD_NS;
	localparam int START_DELAY_CYC   = 1024;
	localparam int PLL_FACTOR        = 4;
	localparam int CLKOUT_DIV        = 4;

	// Register byte offsets
	localparam logic [11:0] CTRL_OFS   = 12'h000;
	localparam logic [11:0] TUNE_OFS   = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;

	// Control register fields and reset values
	localparam int          IFS_LSB   = 4;
	localparam logic [2:0]  IFS_RESET = 3'h0;

	// Tuning register fields and reset values
	localparam int          SRCSEL_BIT  = 7;
	localparam int          MULEN_BIT   = 6;
	localparam logic [4:0]  TRIM_RESET  = 5'h00;

	// Status register fields
	localparam int ST_MODE_LSB  = 0;
	localparam int ST_XPLL_BIT  = 4;
	localparam int ST_IPLL_BIT  = 5;
	localparam int ST_FAST_BIT  = 6;
	localparam int ST_SLOW_BIT  = 7;
	localparam int ST_RUN_BIT   = 8;

	// Oscillator mode encodings
	localparam logic [3:0] MODE_LP_XTAL   = 4'h0;
	localparam logic [3:0] MODE_STD_XTAL  = 4'h1;
	localparam logic [3:0] MODE_FAST_XTAL = 4'h2;
	localparam logic [3:0] MODE_RC_CLKOUT = 4'h3;
	localparam logic [3:0] MODE_EXT_DIV   = 4'h4;
	localparam logic [3:0] MODE_EXT_GPIO  = 4'h5;
	localparam logic [3:0] MODE_XTAL_PLL  = 4'h6;
	localparam logic [3:0] MODE_RC_GPIO   = 4'h7;
	localparam logic [3:0] MODE_INT_DUAL  = 4'h8;
	localparam logic [3:0] MODE_INT_CLKO  = 4'h9;

	// Internal frequency select encodings
	localparam logic [2:0] IFS_8MHZ   = 3'h7;
	localparam logic [2:0] IFS_4MHZ   = 3'h6;
	localparam logic [2:0] IFS_31KHZ  = 3'h0;

	// Start-up sequencer states, Gray along load-wait-run-sleep
	typedef enum logic [1:0] {
		ST_LOAD  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_RUN   = 2'b11,
		ST_SLEEP = 2'b10
	} omsp_state_e;

endpackage

// ==== sim/omsp_osc_model.sv ====
`timescale 1ns/10ps
module omsp_osc_model (
	input  wire logic pclk,
	input  wire logic ext_on,
	input  wire logic gpio_lvl,
	input  wire logic in_out,
	input  wire logic in_oe,
	input  wire logic out_out,
	input  wire logic out_oe,
	output logic      in_pin,
	output logic      out_pin
);
	logic clk_q = 1'b0;
	logic out_last = 1'b0;

	// External clock source and last seen output level
	always @(posedge pclk) begin
		clk_q    <= ext_on ? ~clk_q : 1'b0;
		out_last <= out_pin;
	end

	// Input pin: device, external clock, else board level
	assign in_pin  = in_oe ? in_out : (ext_on ? clk_q : gpio_lvl);
	// Released output pin shows no stale level
	assign out_pin = out_oe ? out_out : ~out_last;
endmodule

// ==== sim/omsp_top_assertions.sv ====
`timescale 1ns/10ps
module omsp_chk
	import omsp_pkg::*;
#(
	parameter int FAST_SETTLE = 20,
	parameter int SLOW_SETTLE = 12,
	parameter int START_DELAY = 5
)(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [3:0] oscillator_mode_field,
	input wire logic       pwrup_timer_en,
	input wire logic       failsafe_mon_en,
	input wire logic       watchdog_en,
	input wire logic       two_speed_en,
	input wire logic       oscillator_output_pin_oe,
	input wire logic       resonator_en,
	input wire logic       xtal_pll_en,
	input wire logic       int_pll_en,
	input wire logic       fast_osc_en,
	input wire logic       slow_osc_en,
	input wire logic [2:0] internal_frequency_select,
	input wire logic       slow_from_fast,
	input wire logic [4:0] fast_trim,
	input wire logic       fast_trim_settling,
	input wire logic       sys_clk_run
);
	logic intm;
	logic extm;
	logic xtm;
	logic fast_sel;

	// Mode classes from the strap
	assign intm     = oscillator_mode_field inside {MODE_INT_DUAL, MODE_INT_CLKO};
	assign extm     = oscillator_mode_field inside {MODE_EXT_DIV, MODE_EXT_GPIO};
	assign xtm      = oscillator_mode_field inside {MODE_LP_XTAL, MODE_STD_XTAL, MODE_FAST_XTAL, MODE_XTAL_PLL};
	assign fast_sel = internal_frequency_select inside {IFS_8MHZ, IFS_4MHZ};

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Multiplier paths
	a_xpll_only: assert property (xtal_pll_en |-> oscillator_mode_field == MODE_XTAL_PLL)
		else $error("crystal multiplier outside its mode");
	a_xpll_fixed: assert property (sys_clk_run && oscillator_mode_field == MODE_XTAL_PLL |-> xtal_pll_en && !int_pll_en)
		else $error("crystal multiplier mode wrong");
	a_ipll_gate: assert property (int_pll_en |-> intm && fast_sel)
		else $error("internal multiplier on when not allowed");
	// Pin use per mode
	a_resonator_pins: assert property (sys_clk_run && xtm |-> resonator_en && !oscillator_output_pin_oe)
		else $error("resonator pins not kept");
	a_clkout_drive: assert property (sys_clk_run && oscillator_mode_field inside {4'h3, 4'h4, 4'h9}
		|-> oscillator_output_pin_oe)
		else $error("divided clock not driven");
	a_ext_nodelay: assert property ($rose(presetn) && extm |-> ##[1:2] sys_clk_run)
		else $error("external clock start delayed");
	// Oscillator enables
	a_slow_auto: assert property (pwrup_timer_en || failsafe_mon_en || watchdog_en || two_speed_en
		|-> ##[0:2] slow_osc_en)
		else $error("slow oscillator not forced on");
	a_fast_on: assert property (intm && fast_sel |-> fast_osc_en)
		else $error("fast oscillator off");
	a_slow_src: assert property (intm && internal_frequency_select == IFS_31KHZ && slow_from_fast |-> fast_osc_en)
		else $error("31k source from fast oscillator off");
	// Tuning settle window
	a_tune_settle: assert property ($changed(fast_trim) |-> fast_trim_settling [*8])
		else $error("tuning settle too short");
	a_settle_ends: assert property ($rose(fast_trim_settling) |-> ##[1:40] !fast_trim_settling)
		else $error("tuning settle never ends");

	c_int_pll: cover property (int_pll_en);
	c_xtal_pll: cover property (xtal_pll_en);
	c_settled: cover property ($fell(fast_trim_settling));
endmodule

bind omsp_top omsp_chk #(.FAST_SETTLE(FAST_SETTLE), .SLOW_SETTLE(SLOW_SETTLE), .START_DELAY(START_DELAY)) u_chk (
	.pclk, .presetn, .oscillator_mode_field, .pwrup_timer_en, .failsafe_mon_en, .watchdog_en, .two_speed_en,
	.oscillator_output_pin_oe, .resonator_en, .xtal_pll_en, .int_pll_en, .fast_osc_en, .slow_osc_en,
	.internal_frequency_select, .slow_from_fast, .fast_trim, .fast_trim_settling, .sys_clk_run);

// ==== sim/omsp_top_bench.sv ====
`timescale 1ns/10ps
module omsp_top_bench
	import omsp_pkg::*;
();
	logic        pclk, presetn, psel, penable, pwrite, sleep_req, ext_on, er, ce;
	logic        port_a_bit_six_out, port_a_bit_six_oe, port_a_bit_seven_out, port_a_bit_seven_oe;
	logic        rc_osc_en, postscaler_en, slow_trim_settling;
	logic        pwrup_timer_en, failsafe_mon_en, watchdog_en, two_speed_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  oscillator_mode_field;
	logic [2:0]  internal_frequency_select;
	logic [4:0]  fast_trim;
	logic        pready, pslverr, resonator_en, ext_clock_accept, xtal_pll_en, int_pll_en, fast_osc_en;
	logic        slow_osc_en, slow_from_fast, fast_trim_settling, sys_clk_run, port_a_bit_six_in;
	logic        oscillator_input_pin_in, oscillator_input_pin_out, oscillator_input_pin_oe;
	logic        oscillator_output_pin_in, oscillator_output_pin_out, oscillator_output_pin_oe;
	logic        port_a_bit_seven_in;
	int          error_cnt, total_checks;

	omsp_top #(.FAST_SETTLE(20), .SLOW_SETTLE(12), .START_DELAY(5)) DUT (.pclk, .presetn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .oscillator_mode_field, .sleep_req,
		.pwrup_timer_en, .failsafe_mon_en, .watchdog_en, .two_speed_en, .oscillator_input_pin_in,
		.oscillator_input_pin_out, .oscillator_input_pin_oe, .oscillator_output_pin_in, .oscillator_output_pin_out,
		.oscillator_output_pin_oe, .port_a_bit_six_out, .port_a_bit_six_oe, .port_a_bit_six_in,
		.port_a_bit_seven_out, .port_a_bit_seven_oe, .port_a_bit_seven_in, .resonator_en,
		.ext_clock_accept, .rc_osc_en, .xtal_pll_en, .int_pll_en, .fast_osc_en, .slow_osc_en, .postscaler_en,
		.internal_frequency_select, .slow_from_fast, .fast_trim, .fast_trim_settling, .slow_trim_settling,
		.sys_clk_run);

	omsp_osc_model u_far (.pclk, .ext_on, .gpio_lvl(1'b1), .in_out(oscillator_input_pin_out),
		.in_oe(oscillator_input_pin_oe), .out_out(oscillator_output_pin_out), .out_oe(oscillator_output_pin_oe),
		.in_pin(oscillator_input_pin_in), .out_pin(oscillator_output_pin_in));

	// Bus clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic rst(input logic [3:0] m, output int c);
		c = 0;
		presetn <= 1'b0;
		oscillator_mode_field <= m;
		ext_on <= m inside {MODE_FAST_XTAL, MODE_EXT_DIV, MODE_EXT_GPIO};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		do begin
			@(posedge pclk);
			c++;
		end while (sys_clk_run !== 1'b1 && c < 40);
		chk("started", 1, c < 40);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic t_modes();
		int c, rises;
		logic [3:0] m;
		logic clko, gp6, prev;
		for (int i = 0; i < 10; i++) begin
			m = 4'(i);
			clko = m inside {MODE_RC_CLKOUT, MODE_EXT_DIV, MODE_INT_CLKO};
			gp6 = m inside {MODE_EXT_GPIO, MODE_RC_GPIO, MODE_INT_DUAL};
			rst(m, c);
			if (m inside {MODE_EXT_DIV, MODE_EXT_GPIO}) chk("ext start", 1, c <= 3);
			if (m inside {MODE_FAST_XTAL, MODE_EXT_DIV, MODE_EXT_GPIO}) chk("ext accept", 1, ext_clock_accept);
			chk("out oe", clko | gp6, oscillator_output_pin_oe);
			chk("six in", gp6, port_a_bit_six_in);
			chk("seven in", m inside {MODE_INT_DUAL, MODE_INT_CLKO}, port_a_bit_seven_in);
			chk("resonator", m inside {0, 1, 2, 6}, resonator_en);
			chk("rc osc", m inside {MODE_RC_CLKOUT, MODE_RC_GPIO}, rc_osc_en);
			chk("xtal pll", m == MODE_XTAL_PLL, xtal_pll_en);
			rises = 0;
			prev = oscillator_output_pin_out;
			repeat (16) begin
				@(posedge pclk);
				rises += int'(oscillator_output_pin_out & ~prev);
				prev = oscillator_output_pin_out;
			end
			chk("div4 rises", clko ? 4 : 0, rises);
			port_a_bit_six_out <= 1'b0;
			port_a_bit_seven_out <= 1'b0;
			port_a_bit_seven_oe <= 1'b1;
			repeat (3) @(posedge pclk);
			chk("seven oe", m inside {MODE_INT_DUAL, MODE_INT_CLKO}, oscillator_input_pin_oe);
			chk("pins low", 0, {port_a_bit_six_in, port_a_bit_seven_in});
			port_a_bit_six_out <= 1'b1;
			port_a_bit_seven_out <= 1'b1;
			port_a_bit_seven_oe <= 1'b0;
			apb(0, STATUS_OFS, 0);
			chk("status", {m, 1'b1}, {rd[3:0], rd[ST_RUN_BIT]});
		end
	endtask

	task automatic t_sleep();
		int c;
		rst(MODE_EXT_GPIO, c);
		ce <= 1'b0;
		sleep_req <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("frozen", 1, sys_clk_run);
		ce <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("asleep", 0, sys_clk_run);
		sleep_req <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("awake", 1, sys_clk_run);
	endtask

	task automatic t_ipll();
		int c;
		rst(MODE_INT_CLKO, c);
		apb(1, CTRL_OFS, 32'h0000_0070);
		apb(1, TUNE_OFS, 32'h0000_0060);
		chk("ipll on", 1, int_pll_en);
		chk("fast on", 1, fast_osc_en);
		chk("ifs out", 7, internal_frequency_select);
		chk("post 8m", 0, postscaler_en);
		chk("slow off", 0, slow_osc_en);
		for (int k = 0; k < 4; k++) begin
			{pwrup_timer_en, failsafe_mon_en, watchdog_en, two_speed_en} <= 4'h8 >> k;
			repeat (3) @(posedge pclk);
			chk("slow auto", 1, slow_osc_en);
		end
		{pwrup_timer_en, failsafe_mon_en, watchdog_en, two_speed_en} <= 4'h0;
		apb(0, TUNE_OFS, 0);
		chk("tune rd", 32'h0000_0040, rd);
		apb(0, CTRL_OFS, 0);
		chk("ctrl rd", 32'h0000_0070, rd);
		apb(1, CTRL_OFS, 32'h0000_0060);
		chk("ipll 4m", 1, int_pll_en);
		chk("post 4m", 1, postscaler_en);
		apb(1, TUNE_OFS, 32'h0000_00c0);
		apb(1, CTRL_OFS, 0);
		chk("ipll 31k", 0, int_pll_en);
		chk("src fast", 1, slow_from_fast & fast_osc_en);
		apb(1, TUNE_OFS, 0);
		chk("src slow", 1, slow_osc_en);
		apb(1, 12'h00c, 32'hffff_ffff);
		chk("unmapped", 1, er);
		apb(1, STATUS_OFS, 0);
		apb(0, STATUS_OFS, 0);
		chk("status ro", MODE_INT_CLKO, rd[3:0]);
	endtask

	task automatic t_xpll();
		int c;
		rst(MODE_XTAL_PLL, c);
		apb(1, TUNE_OFS, 32'h0000_0045);
		chk("trim", 5, fast_trim);
		chk("settling", 1, fast_trim_settling);
		chk("slow settling", 1, slow_trim_settling);
		chk("mul ignored", 0, int_pll_en);
		apb(0, TUNE_OFS, 0);
		chk("mul forced", 32'h0000_0005, rd);
		c = 0;
		do @(posedge pclk); while (fast_trim_settling !== 1'b0 && ++c < 40);
		chk("settle span", 1, c > 10 && c < 40);
		chk("slow settled", 0, slow_trim_settling);
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, sleep_req, ext_on} = 6'h0;
		{pwrup_timer_en, failsafe_mon_en, watchdog_en, two_speed_en} = 4'h0;
		{ce, port_a_bit_six_out, port_a_bit_six_oe, port_a_bit_seven_out, port_a_bit_seven_oe} = 5'h1e;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		oscillator_mode_field = 4'h0;
		t_modes();
		t_sleep();
		t_ipll();
		t_xpll();
		finish_test();
	end

	// Hang guard
	initial begin
		#1_000_000;
		error_cnt++;
		finish_test();
	end
endmodule
